// file: core/mpfs_port_block.sv
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mpfs_port_block (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        nrst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [mpfs_pkg::ADDR_W-1:0] paddr,
  input  wire logic [mpfs_pkg::DATA_W-1:0] pwdata,
  output logic      [mpfs_pkg::DATA_W-1:0] prdata,
  output logic                             pready,
  output logic                             pslverr,
  // port 0
  input  wire logic [mpfs_pkg::P0_W-1:0]   p0_in,
  output logic      [mpfs_pkg::P0_W-1:0]   p0_out,
  output logic      [mpfs_pkg::P0_W-1:0]   p0_oe,
  output logic      [mpfs_pkg::P0_W-1:0]   p0_pullup,
  // port 1
  input  wire logic [mpfs_pkg::P1_W-1:0]   p1_in,
  output logic      [mpfs_pkg::P1_W-1:0]   p1_out,
  output logic      [mpfs_pkg::P1_W-1:0]   p1_oe,
  output logic      [mpfs_pkg::P1_W-1:0]   p1_pullup,
  // port 2
  input  wire logic [mpfs_pkg::P2_W-1:0]   p2_in,
  output logic      [mpfs_pkg::P2_W-1:0]   p2_out,
  output logic      [mpfs_pkg::P2_W-1:0]   p2_oe,
  output logic      [mpfs_pkg::P2_W-1:0]   p2_pullup,
  // port 3
  input  wire logic [mpfs_pkg::P3_W-1:0]   p3_in,
  output logic      [mpfs_pkg::P3_W-1:0]   p3_out,
  output logic      [mpfs_pkg::P3_W-1:0]   p3_oe,
  output logic      [mpfs_pkg::P3_W-1:0]   p3_pullup,
  // port 6 and port 8
  input  wire logic [mpfs_pkg::P6_W-1:0]   p6_in,
  input  wire logic [mpfs_pkg::P8_W-1:0]   p8_in,
  output logic      [mpfs_pkg::P8_W-1:0]   p8_out,
  output logic      [mpfs_pkg::P8_W-1:0]   p8_oe,
  // on-chip peripherals, same clock
  input  wire logic                        sync_serial_data_out,
  input  wire logic                        sync_serial_clock_out,
  input  wire logic                        async_serial_transmit_pin,
  input  wire logic                        timer_a_output,
  input  wire logic                        timer_b_output,
  input  wire logic [mpfs_pkg::P3_W-1:0]   sound_freq_outputs,
  input  wire logic [mpfs_pkg::P8_W-1:0]   lcd_shared_outputs,
  output logic                             sync_serial_data_in,
  output logic                             async_serial_receive_pin,
  output logic                             sync_serial_clock_in,
  output logic                             timer_external_clock_in,
  output logic                             remote_timer_input,
  output logic      [mpfs_pkg::KR_N-1:0]   key_return_inputs,
  output logic                             key_return_detect,
  output logic                             ext_interrupt_in_a,
  output logic                             ext_interrupt_in_b,
  output logic      [mpfs_pkg::P6_W-1:0]   analog_inputs_sel
);
  import mpfs_pkg::*;

  mpfs_state_t st;
  mpfs_state_t next_st;

  mpfs_edge_if #(.N(EDGE_N)) edge_bus ();

  logic [P0_W-1:0] s_p0;
  logic [P1_W-1:0] s_p1;
  logic [P2_W-1:0] s_p2;
  logic [P3_W-1:0] s_p3;
  logic [P6_W-1:0] s_p6;
  logic [P8_W-1:0] s_p8;
  logic [P2_W-1:0] p2_alt;
  logic            wr_go;
  logic            rd_go;

  // input pins after the two-stage synchroniser
  assign s_p0 = st.sync2[P0_LSB +: P0_W];
  assign s_p1 = st.sync2[P1_LSB +: P1_W];
  assign s_p2 = st.sync2[P2_LSB +: P2_W];
  assign s_p3 = st.sync2[P3_LSB +: P3_W];
  assign s_p6 = st.sync2[P6_LSB +: P6_W];
  assign s_p8 = st.sync2[P8_LSB +: P8_W];

  assign edge_bus.level = {s_p2[P2_INTB], s_p2[P2_INTA], s_p0};
  assign edge_bus.cfg   = {st.ext_cfg[EXT_B_LSB +: 2],
                           st.ext_cfg[EXT_A_LSB +: 2],
                           {KR_N{EDGE_FALL}}};

  mpfs_edge_det #(.N(EDGE_N)) u_edge (
    .clk  (clk),
    .nrst (nrst),
    .bus  (edge_bus.det)
  );

  // output bits are the latch, input bits are the pin
  function automatic logic [7:0] port_read(input logic [7:0] latch,
                                           input logic [7:0] dir,
                                           input logic [7:0] pin);
    return (dir & pin) | (~dir & latch);
  endfunction

  assign wr_go = psel & penable & st.pready & pwrite;
  assign rd_go = psel & penable & ~st.pready;

  always_comb begin
    p2_alt         = st.p2_latch;
    p2_alt[P2_SCK] = sync_serial_clock_out;
    p2_alt[P2_TX]  = st.ext_cfg[EXT_ASYNC] ? async_serial_transmit_pin
                                           : sync_serial_data_out;
    p2_alt[P2_TOB] = timer_b_output;
    p2_alt[P2_TOA] = timer_a_output;
  end

  always_comb begin
    next_st       = st;
    next_st.sync1 = {p8_in, p6_in, p3_in, p2_in, p1_in, p0_in};
    next_st.sync2 = st.sync1;

    // one wait state: ready rises in the cycle after penable
    next_st.pready  = rd_go;
    next_st.pslverr = 1'b0;
    if (rd_go) begin
      next_st.prdata = '0;
      case (paddr)
        OFS_P0_DATA:  next_st.prdata = 32'(port_read(st.p0_latch,
                                           st.p0_dir, s_p0));
        OFS_P0_DIR:   next_st.prdata = 32'(st.p0_dir);
        OFS_P0_CTL:   next_st.prdata = 32'(st.p0_ctl);
        OFS_P1_DATA:  next_st.prdata = 32'(port_read({6'h00, st.p1_latch},
                                           {6'h00, st.p1_dir},
                                           {6'h00, s_p1}));
        OFS_P1_DIR:   next_st.prdata = 32'(st.p1_dir);
        OFS_PU01:     next_st.prdata = 32'(st.pu01);
        OFS_P2_DATA:  next_st.prdata = 32'(port_read(st.p2_latch,
                                           st.p2_dir, s_p2));
        OFS_P2_DIR:   next_st.prdata = 32'(st.p2_dir);
        OFS_P2_PU:    next_st.prdata = 32'(st.p2_pu);
        OFS_P2_CTL:   next_st.prdata = 32'(st.p2_ctl);
        OFS_EXT_CFG:  next_st.prdata = 32'(st.ext_cfg);
        OFS_P3_DATA:  next_st.prdata = 32'(port_read(st.p3_latch,
                                           st.p3_dir, s_p3));
        OFS_P3_DIR:   next_st.prdata = 32'(st.p3_dir);
        OFS_P3_PU:    next_st.prdata = 32'(st.p3_pu);
        OFS_P3_FUNC:  next_st.prdata = 32'(st.p3_func);
        OFS_P6_CTL:   next_st.prdata = 32'(st.p6_ctl);
        // analog pins read as zero on the digital path
        OFS_P6_DATA:  next_st.prdata = 32'(s_p6 & ~st.p6_ctl);
        OFS_LCD_MODE: next_st.prdata = 32'(st.lcd_mode);
        OFS_P8_DATA:  next_st.prdata = 32'(s_p8 & {P8_W{~st.lcd_mode}});
        default:      next_st.pslverr = 1'b1;
      endcase
    end

    if (wr_go) begin
      case (paddr)
        OFS_P0_DATA:  next_st.p0_latch = pwdata[P0_W-1:0];
        OFS_P0_DIR:   next_st.p0_dir   = pwdata[P0_W-1:0];
        OFS_P0_CTL:   next_st.p0_ctl   = pwdata[P0_W-1:0];
        OFS_P1_DATA:  next_st.p1_latch = pwdata[P1_W-1:0];
        OFS_P1_DIR:   next_st.p1_dir   = pwdata[P1_W-1:0];
        OFS_PU01:     next_st.pu01     = pwdata[1:0];
        OFS_P2_DATA:  next_st.p2_latch = pwdata[P2_W-1:0];
        OFS_P2_DIR:   next_st.p2_dir   = pwdata[P2_W-1:0];
        OFS_P2_PU:    next_st.p2_pu    = pwdata[P2_W-1:0];
        OFS_P2_CTL:   next_st.p2_ctl   = pwdata[P2_W-1:0];
        OFS_EXT_CFG:  next_st.ext_cfg  = pwdata[EXT_CFG_W-1:0];
        OFS_P3_DATA:  next_st.p3_latch = pwdata[P3_W-1:0];
        OFS_P3_DIR:   next_st.p3_dir   = pwdata[P3_W-1:0];
        OFS_P3_PU:    next_st.p3_pu    = pwdata[P3_W-1:0];
        OFS_P3_FUNC:  next_st.p3_func  = pwdata[0];
        OFS_P6_CTL:   next_st.p6_ctl   = pwdata[P6_W-1:0];
        OFS_LCD_MODE: next_st.lcd_mode = pwdata[0];
        default: ;
      endcase
    end

    // pin drivers; port 6 bits never drive
    next_st.drv_out = '0;
    next_st.drv_oe  = '0;
    next_st.pull    = '0;
    next_st.drv_out[P0_LSB +: P0_W] = st.p0_latch;
    next_st.drv_oe[P0_LSB +: P0_W]  = ~st.p0_dir & ~st.p0_ctl;
    next_st.pull[P0_LSB +: P0_W]    = {P0_W{st.pu01[0]}} & st.p0_dir
                                      & ~st.p0_ctl;
    next_st.drv_out[P1_LSB +: P1_W] = st.p1_latch;
    next_st.drv_oe[P1_LSB +: P1_W]  = ~st.p1_dir;
    next_st.pull[P1_LSB +: P1_W]    = {P1_W{st.pu01[1]}}
                                      & st.p1_dir;
    // in control mode port 2 direction still follows its register
    next_st.drv_out[P2_LSB +: P2_W] = (st.p2_ctl & p2_alt)
                                      | (~st.p2_ctl & st.p2_latch);
    next_st.drv_oe[P2_LSB +: P2_W]  = ~st.p2_dir;
    next_st.pull[P2_LSB +: P2_W]    = st.p2_pu & st.p2_dir
                                      & ~st.p2_ctl;
    next_st.drv_out[P3_LSB +: P3_W] = st.p3_func ? sound_freq_outputs
                                                 : st.p3_latch;
    next_st.drv_oe[P3_LSB +: P3_W]  = st.p3_func ? {P3_W{1'b1}}
                                                 : ~st.p3_dir;
    next_st.pull[P3_LSB +: P3_W]    = st.p3_pu & st.p3_dir
                                      & {P3_W{~st.p3_func}};
    next_st.drv_out[P8_LSB +: P8_W] = lcd_shared_outputs;
    next_st.drv_oe[P8_LSB +: P8_W]  = {P8_W{st.lcd_mode}};

    // key return and serial inputs idle high when their pin is in port mode; timer clock and remote inputs idle low
    next_st.kr_level = s_p0 | ~st.p0_ctl;
    next_st.kr_det   = |(edge_bus.pulse[KR_N-1:0] & st.p0_ctl);
    next_st.ext_a    = edge_bus.pulse[CH_EXT_A] & st.p2_ctl[P2_INTA];
    next_st.ext_b    = edge_bus.pulse[CH_EXT_B] & st.p2_ctl[P2_INTB];
    next_st.ser_in   = s_p2[P2_RX] | ~st.p2_ctl[P2_RX];
    next_st.sck_in   = s_p2[P2_SCK] | ~st.p2_ctl[P2_SCK];
    next_st.ti       = s_p2[P2_INTA] & st.p2_ctl[P2_INTA];
    next_st.remote   = s_p2[P2_REMOTE] & st.p2_ctl[P2_REMOTE];

    if (!nrst) begin
      next_st          = '0;
      next_st.p0_latch = RST_LATCH;
      next_st.p0_dir   = RST_DIR;
      next_st.p0_ctl   = RST_CTL;
      next_st.p1_latch = RST_LATCH[P1_W-1:0];
      next_st.p1_dir   = RST_DIR[P1_W-1:0];
      next_st.pu01     = RST_PU[1:0];
      next_st.p2_latch = RST_LATCH;
      next_st.p2_dir   = RST_DIR;
      next_st.p2_pu    = RST_PU;
      next_st.p2_ctl   = RST_CTL;
      next_st.ext_cfg  = RST_EXT_CFG;
      next_st.p3_latch = RST_LATCH;
      next_st.p3_dir   = RST_DIR;
      next_st.p3_pu    = RST_PU;
      next_st.p3_func  = RST_P3_FUNC;
      next_st.p6_ctl   = RST_P6_CTL;
      next_st.lcd_mode = RST_LCD_MODE;
      // lcd pins drive from reset on, as the mode register says
      next_st.drv_oe[P8_LSB +: P8_W] = {P8_W{RST_LCD_MODE}};
      next_st.kr_level = {KR_N{1'b1}};
      next_st.ser_in   = 1'b1;
      next_st.sck_in   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign p0_out    = st.drv_out[P0_LSB +: P0_W];
  assign p0_oe     = st.drv_oe[P0_LSB +: P0_W];
  assign p0_pullup = st.pull[P0_LSB +: P0_W];
  assign p1_out    = st.drv_out[P1_LSB +: P1_W];
  assign p1_oe     = st.drv_oe[P1_LSB +: P1_W];
  assign p1_pullup = st.pull[P1_LSB +: P1_W];
  assign p2_out    = st.drv_out[P2_LSB +: P2_W];
  assign p2_oe     = st.drv_oe[P2_LSB +: P2_W];
  assign p2_pullup = st.pull[P2_LSB +: P2_W];
  assign p3_out    = st.drv_out[P3_LSB +: P3_W];
  assign p3_oe     = st.drv_oe[P3_LSB +: P3_W];
  assign p3_pullup = st.pull[P3_LSB +: P3_W];
  assign p8_out    = st.drv_out[P8_LSB +: P8_W];
  assign p8_oe     = st.drv_oe[P8_LSB +: P8_W];

  assign sync_serial_data_in      = st.ser_in;
  assign async_serial_receive_pin = st.ser_in;
  assign sync_serial_clock_in     = st.sck_in;
  assign timer_external_clock_in  = st.ti;
  assign remote_timer_input       = st.remote;
  assign key_return_inputs        = st.kr_level;
  assign key_return_detect        = st.kr_det;
  assign ext_interrupt_in_a       = st.ext_a;
  assign ext_interrupt_in_b       = st.ext_b;
  assign analog_inputs_sel        = st.p6_ctl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  p0_drive_dir_a: assert property (
    p0_oe == ($past(~st.p0_dir) & $past(~st.p0_ctl)))
    else $error("port 0 enable does not follow direction");
  p01_pull_port_a: assert property (
    (p1_pullup != 2'h0) |-> $past(st.pu01[1]))
    else $error("port 1 pull-up without whole-port option");
  kr_detect_src_a: assert property (
    key_return_detect |-> $past(st.p0_ctl, 2) != 8'h00)
    else $error("key return seen with no bit in control mode");
  p1_drive_dir_a: assert property (
    p1_oe == ~$past(st.p1_dir))
    else $error("port 1 enable does not follow direction");
  p2_pull_opt_a: assert property (
    (p2_pullup & ~$past(st.p2_pu & st.p2_dir)) == 8'h00)
    else $error("port 2 pull-up outside its option");
  p2_timer_out_a: assert property (
    $past(st.p2_ctl[P2_TOA]) |-> p2_out[P2_TOA] == $past(timer_a_output))
    else $error("port 2 bit 7 not carrying the timer output");
  ext_rise_only_a: assert property (
    (ext_interrupt_in_a && $past(st.ext_cfg[1:0], 2) == EDGE_RISE)
      |-> $past(s_p2[P2_INTA], 2) && !$past(s_p2[P2_INTA], 3))
    else $error("interrupt a fired without a rising edge");
  p3_sound_mode_a: assert property (
    $past(st.p3_func) |-> p3_oe == 8'hff && p3_out == $past(sound_freq_outputs))
    else $error("port 3 not driving sound outputs");
  p3_pull_bit_a: assert property (
    (p3_pullup & ~$past(st.p3_pu)) == 8'h00)
    else $error("port 3 pull-up outside its option");
  p6_never_drive_a: assert property (
    st.drv_oe[P6_LSB +: P6_W] == 3'h0)
    else $error("port 6 driver enabled");
  p8_lcd_mode_a: assert property (
    p8_oe == {P8_W{$past(st.lcd_mode)}})
    else $error("port 8 enable does not follow lcd mode");
  pull_no_drive_a: assert property (
    (st.pull & st.drv_oe) == '0)
    else $error("pull-up on a driven pin");
  apb_one_wait_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not one cycle after penable");

  kr_event_cov:  cover property (key_return_detect);
  ext_b_cov:     cover property (ext_interrupt_in_b);
  apb_error_cov: cover property (pready && pslverr);
  sound_cov:     cover property (st.p3_func && p3_oe == 8'hff);
endmodule
`default_nettype wire

// file: core/mpfs_pkg.sv
package mpfs_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // pin groups and their place in the combined pin vector
  localparam int P0_W   = 8;
  localparam int P1_W   = 2;
  localparam int P2_W   = 8;
  localparam int P3_W   = 8;
  localparam int P6_W   = 3;
  localparam int P8_W   = 8;
  localparam int P0_LSB = 0;
  localparam int P1_LSB = 8;
  localparam int P2_LSB = 10;
  localparam int P3_LSB = 18;
  localparam int P6_LSB = 26;
  localparam int P8_LSB = 29;
  localparam int PIN_W  = 37;

  // port 2 alternate function bit positions
  localparam int P2_SCK  = 0;
  localparam int P2_TX   = 1;
  localparam int P2_RX   = 2;
  localparam int P2_INTA = 3;
  localparam int P2_INTB = 4;
  localparam int P2_TOB  = 5;
  localparam int P2_REMOTE = 6;
  localparam int P2_TOA  = 7;

  // register byte offsets
  localparam logic [7:0] OFS_P0_DATA  = 8'h00;
  localparam logic [7:0] OFS_P0_DIR   = 8'h04;
  localparam logic [7:0] OFS_P0_CTL   = 8'h08;
  localparam logic [7:0] OFS_P1_DATA  = 8'h0c;
  localparam logic [7:0] OFS_P1_DIR   = 8'h10;
  localparam logic [7:0] OFS_PU01     = 8'h14;
  localparam logic [7:0] OFS_P2_DATA  = 8'h18;
  localparam logic [7:0] OFS_P2_DIR   = 8'h1c;
  localparam logic [7:0] OFS_P2_PU    = 8'h20;
  localparam logic [7:0] OFS_P2_CTL   = 8'h24;
  localparam logic [7:0] OFS_EXT_CFG  = 8'h28;
  localparam logic [7:0] OFS_P3_DATA  = 8'h2c;
  localparam logic [7:0] OFS_P3_DIR   = 8'h30;
  localparam logic [7:0] OFS_P3_PU    = 8'h34;
  localparam logic [7:0] OFS_P3_FUNC  = 8'h38;
  localparam logic [7:0] OFS_P6_CTL   = 8'h3c;
  localparam logic [7:0] OFS_P6_DATA  = 8'h40;
  localparam logic [7:0] OFS_LCD_MODE = 8'h44;
  localparam logic [7:0] OFS_P8_DATA  = 8'h48;

  // edge select fields and async transmit select bit of the external interrupt config register
  localparam int EXT_CFG_W = 5;
  localparam int EXT_A_LSB = 0;
  localparam int EXT_B_LSB = 2;
  localparam int EXT_ASYNC = 4;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam int KR_N     = 8;
  localparam int EDGE_N   = 10;
  localparam int CH_EXT_A = 8;
  localparam int CH_EXT_B = 9;

  // reset values
  localparam logic [7:0] RST_DIR   = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_CTL   = 8'h00;
  localparam logic [7:0] RST_PU    = 8'h00;
  localparam logic [EXT_CFG_W-1:0] RST_EXT_CFG = 5'h00;
  localparam logic       RST_P3_FUNC  = 1'b0;
  localparam logic [2:0] RST_P6_CTL   = 3'h0;
  localparam logic       RST_LCD_MODE = 1'b1;

  typedef struct packed {
    logic [PIN_W-1:0]     sync1;
    logic [PIN_W-1:0]     sync2;
    logic [P0_W-1:0]      p0_latch;
    logic [P0_W-1:0]      p0_dir;
    logic [P0_W-1:0]      p0_ctl;
    logic [P1_W-1:0]      p1_latch;
    logic [P1_W-1:0]      p1_dir;
    logic [1:0]           pu01;
    logic [P2_W-1:0]      p2_latch;
    logic [P2_W-1:0]      p2_dir;
    logic [P2_W-1:0]      p2_pu;
    logic [P2_W-1:0]      p2_ctl;
    logic [EXT_CFG_W-1:0] ext_cfg;
    logic [P3_W-1:0]      p3_latch;
    logic [P3_W-1:0]      p3_dir;
    logic [P3_W-1:0]      p3_pu;
    logic                 p3_func;
    logic [P6_W-1:0]      p6_ctl;
    logic                 lcd_mode;
    logic [PIN_W-1:0]     drv_out;
    logic [PIN_W-1:0]     drv_oe;
    logic [PIN_W-1:0]     pull;
    logic [KR_N-1:0]      kr_level;
    logic                 kr_det;
    logic                 ext_a;
    logic                 ext_b;
    logic                 ser_in;
    logic                 sck_in;
    logic                 ti;
    logic                 remote;
    logic                 pready;
    logic                 pslverr;
    logic [DATA_W-1:0]    prdata;
  } mpfs_state_t;

endpackage

// file: core/mpfs_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mpfs_edge_if #(parameter int N = 10);
  logic [N-1:0]   level;
  logic [2*N-1:0] cfg;
  logic [N-1:0]   pulse;
  modport src (output level, output cfg, input pulse);
  modport det (input level, input cfg, output pulse);
endinterface
`default_nettype wire

// file: core/mpfs_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module mpfs_edge_det #(
  parameter int N = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // levels in, edge pulses out
  mpfs_edge_if.det bus
);
  import mpfs_pkg::*;

  typedef struct packed {
    logic         armed;
    logic [N-1:0] prev;
    logic [N-1:0] pulse;
  } mpfs_edge_state_t;

  mpfs_edge_state_t st;
  mpfs_edge_state_t next_st;

  function automatic logic edge_hit(input logic [1:0] cfg,
                                    input logic prev, input logic cur);
    return (cfg[0] & ~prev & cur) | (cfg[1] & prev & ~cur);
  endfunction

  always_comb begin
    next_st       = st;
    next_st.prev  = bus.level;
    next_st.armed = 1'b1;
    for (int i = 0; i < N; i++) begin
      // first sample after reset only primes prev
      next_st.pulse[i] = st.armed &
        edge_hit(bus.cfg[2*i +: 2], st.prev[i], bus.level[i]);
    end
    if (!nrst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign bus.pulse = st.pulse;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  fall_only_edge_a: assert property (
    (st.pulse[0] && $past(bus.cfg[1:0]) == EDGE_FALL)
      |-> !$past(bus.level[0]) && $past(bus.level[0], 2))
    else $error("falling-only channel pulsed without a fall");
  both_edges_cov: cover property (
    $past(bus.cfg[2*N-1 -: 2]) == EDGE_BOTH && st.pulse[N-1]);
endmodule
`default_nettype wire

// file: test/mpfs_board.sv
`timescale 1ns/1ps
`default_nettype none
module mpfs_board #(
  parameter int W = 26
) (
  // block side
  input  wire logic [W-1:0] out,
  input  wire logic [W-1:0] oe,
  input  wire logic [W-1:0] pu,
  // bench drive
  input  wire logic [W-1:0] xv,
  input  wire logic [W-1:0] xe,
  output logic      [W-1:0] pin
);
  // a released line with no pull floats away from the latch value
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) pin[i] = out[i];
      else if (xe[i]) pin[i] = xv[i];
      else pin[i] = pu[i] | ~out[i];
    end
  end
endmodule
`default_nettype wire

// file: test/multi_port_pin_function_select_test.sv
`timescale 1ns/1ps
`default_nettype none
module multi_port_pin_function_select_test;
  import mpfs_pkg::*;
  logic        clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = '0, snd = '0, lcd = '0, p8_in = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [25:0] xv = '0, xe = '0, pin, out, oe, pu;
  logic [7:0]  p0_out, p0_oe, p0_pu, p2_out, p2_oe, p2_pu, p3_out, p3_oe;
  logic [7:0]  p3_pu, p8_out, p8_oe, kr;
  logic [1:0]  p1_out, p1_oe, p1_pu;
  logic [2:0]  p6_in = '0, ana;
  logic        pready, pslverr, err, krd, exa, exb;
  logic        sdi, ard, sck, tci, rmt, ta = 0, tb = 0;
  int          n_mismatch = 0, n_compared = 0;
  mpfs_port_block u_dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .p0_in(pin[7:0]), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pu),
    .p1_in(pin[9:8]), .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup(p1_pu),
    .p2_in(pin[17:10]), .p2_out(p2_out), .p2_oe(p2_oe), .p2_pullup(p2_pu),
    .p3_in(pin[25:18]), .p3_out(p3_out), .p3_oe(p3_oe), .p3_pullup(p3_pu),
    .p6_in(p6_in), .p8_in(p8_in), .p8_out(p8_out), .p8_oe(p8_oe),
    .sync_serial_data_out(1'b0), .sync_serial_clock_out(1'b0),
    .async_serial_transmit_pin(1'b0), .timer_a_output(ta),
    .timer_b_output(tb), .sound_freq_outputs(snd),
    .lcd_shared_outputs(lcd), .sync_serial_data_in(sdi),
    .async_serial_receive_pin(ard), .sync_serial_clock_in(sck),
    .timer_external_clock_in(tci), .remote_timer_input(rmt),
    .key_return_inputs(kr), .key_return_detect(krd),
    .ext_interrupt_in_a(exa), .ext_interrupt_in_b(exb),
    .analog_inputs_sel(ana));
  assign out = {p3_out, p2_out, p1_out, p0_out};
  assign oe = {p3_oe, p2_oe, p1_oe, p0_oe};
  assign pu = {p3_pu, p2_pu, p1_pu, p0_pu};
  mpfs_board #(.W(26)) u_board (.out(out), .oe(oe), .pu(pu), .xv(xv),
    .xe(xe), .pin(pin));
  always #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  task automatic t_ports();
    chk({p0_oe, p1_oe, p2_oe, p3_oe}, 32'h0);
    chk({p0_pu, p1_pu, p2_pu, p3_pu}, 32'h0);
    chk({p8_oe, kr, sdi, ard, sck, tci, rmt}, 32'h1ffffc);
    xe <= 26'h00f;
    xv <= 26'h003;
    apb(1, OFS_P0_DIR, 32'h0f);
    apb(1, OFS_P0_DATA, 32'ha5);
    apb(1, OFS_P1_DIR, 32'h2);
    apb(1, OFS_P1_DATA, 32'h1);
    apb(1, OFS_PU01, 32'h1);
    settle();
    chk({p0_oe, p0_out[7:4], p1_oe, p1_out[0]},
        {8'hf0, 4'ha, 3'h3});
    chk({p0_pu, p1_pu}, {8'h0f, 2'h0});
    apb(0, OFS_P0_DATA, 32'h0);
    chk(rd, 32'ha3);
    apb(1, OFS_PU01, 32'h3);
    settle();
    chk({p0_pu, p1_pu}, {8'h0f, 2'h2});
    apb(0, 8'hfc, 32'h0);
    chk(err, 1'b1);
    $display("test ports done");
  endtask
  task automatic t_keys();
    int n;
    apb(1, OFS_P0_CTL, 32'h1);
    settle();
    chk({p0_pu, kr}, 16'h0eff);
    n = 0;
    xv <= 26'h0;
    repeat (8) begin
      @(posedge clk);
      n += (krd === 1'b1);
    end
    chk(n, 1);
    chk(kr, 32'hfe);
    $display("test keys done");
  endtask
  task automatic t_ext();
    int n;
    int e[4];
    e = '{0, 2, 2, 4};
    xe <= 26'h600f;
    apb(1, OFS_P2_CTL, 32'h18);
    apb(1, OFS_P2_PU, 32'hff);
    settle();
    chk(p2_pu, 8'he7);
    for (int c = 0; c < 4; c++) begin
      apb(1, OFS_EXT_CFG, {28'h0, c[1:0], c[1:0]});
      n = 0;
      xv <= 26'h6000;
      // rise at the start, fall halfway: each edge has time to show
      for (int k = 0; k < 16; k++) begin
        @(posedge clk);
        n += (exa === 1'b1) + (exb === 1'b1);
        if (k == 7) xv <= 26'h0;
      end
      chk(n, e[c]);
      xv <= 26'h0;
      settle();
    end
    $display("test ext done");
  endtask
  task automatic t_alt();
    ta <= 1'b1;
    tb <= 1'b1;
    xe <= 26'h1700f;
    xv <= 26'h12000;
    apb(1, OFS_P2_DIR, 32'h5c);
    apb(1, OFS_P2_CTL, 32'hff);
    settle();
    chk({p2_oe, p2_out}, 16'ha3a0);
    chk({sdi, ard, sck, tci, rmt}, 5'h03);
    $display("test alt done");
  endtask
  task automatic t_misc();
    apb(1, OFS_P3_DIR, 32'h0);
    apb(1, OFS_P3_DATA, 32'h3c);
    settle();
    chk({p3_oe, p3_out}, 16'hff3c);
    snd <= 8'h96;
    apb(1, OFS_P3_FUNC, 32'h1);
    settle();
    chk({p3_oe, p3_out}, 16'hff96);
    apb(1, OFS_P3_FUNC, 32'h0);
    apb(1, OFS_P3_DIR, 32'h0f);
    apb(1, OFS_P3_PU, 32'h81);
    lcd <= 8'h5a;
    p8_in <= 8'hc3;
    p6_in <= 3'h6;
    settle();
    chk({p3_oe, p3_pu, p8_oe, p8_out}, 32'hf001ff5a);
    apb(1, OFS_LCD_MODE, 32'h0);
    apb(1, OFS_P6_CTL, 32'h2);
    settle();
    apb(0, OFS_P8_DATA, 32'h0);
    chk({p8_oe, rd[7:0]}, 16'h00c3);
    apb(0, OFS_P6_DATA, 32'h0);
    chk({ana, rd[2:0]}, 6'h14);
    $display("test misc done");
  endtask
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_ports();
    t_keys();
    t_ext();
    t_alt();
    t_misc();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule
`default_nettype wire
